//--- cmt_core.sv
// acceptance masking and bit timing core of the CAN controller
// assumes config inputs are synchronous; writes act only while halted
`timescale 1ns/1ps
module cmt_core #(
  parameter int NUM_MB = 16,
  parameter int NUM_FLT = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic halt_req,
  input cmt_pkg::cmt_cfg_t cfg,
  input cmt_pkg::cmt_wr_t cfg_wr,
  input cmt_pkg::cmt_nom_t nom_cfg,
  input cmt_pkg::cmt_dat_t dat_cfg,
  input wire logic data_phase,
  input cmt_pkg::cmt_rx_t rx,
  output logic frozen_ff,
  output logic hit_valid_ff,
  output logic [NUM_MB-1:0] mb_hit_ff,
  output logic [NUM_FLT-1:0] flt_hit_ff,
  output logic [cmt_pkg::TQ_W-1:0] nom_tq_ff,
  output logic [cmt_pkg::TQ_W-1:0] dat_tq_ff,
  output logic nom_ok_ff,
  output logic dat_ok_ff,
  output logic tq_tick_ff,
  output logic bit_start_ff,
  output logic sample_pt_ff
);
  import cmt_pkg::*;

  typedef enum logic {CMT_RUN, CMT_FRZ} cmt_state_t;

  // address decode shared by the indexed storage words; the global masks decode sel only
  function automatic logic wr_addr(input cmt_wr_t w, input cmt_sel_t s,
                                   input logic [IDX_W-1:0] i);
    wr_addr = (w.sel == s) && (w.idx == i);
  endfunction

  cmt_state_t state_ff;
  cmt_state_t nxt_state;
  cmt_cfg_t cfg_ff;
  cmt_nom_t nom_ff;
  cmt_dat_t dat_ff;
  logic [ID_W-1:0] mb_gmask_ff;
  logic [ID_W-1:0] q_gmask_ff;
  logic [ID_W-1:0] ind_mask_ff [NUM_MB];
  logic [ID_W-1:0] mb_id_ff [NUM_MB];
  logic [ID_W-1:0] flt_id_ff [NUM_FLT];
  logic [PDIV_W-1:0] pdiv_cnt_ff;
  logic [TQ_W-1:0] tq_cnt_ff;

  // halted configuration mode
  wire running = (state_ff == CMT_RUN);
  // writes while running are dropped, no error
  wire wr_ok = cfg_wr.wr && !running;

  always_comb begin
    case (state_ff)
      CMT_RUN: nxt_state = halt_req ? CMT_FRZ : CMT_RUN;
      CMT_FRZ: nxt_state = halt_req ? CMT_FRZ : CMT_RUN;
      // stray code falls back to halted
      default: nxt_state = CMT_FRZ;
    endcase
  end

  // frozen flag mirrors the state for the outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= CMT_FRZ;
      frozen_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      frozen_ff <= (nxt_state == CMT_FRZ);
    end
  end

  // configuration latched only while halted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_ff <= '0;
      nom_ff <= '0;
      dat_ff <= '0;
    end else if (!running) begin
      cfg_ff <= cfg;
      nom_ff <= nom_cfg;
      dat_ff <= dat_cfg;
    end
  end

  wire wr_mb_g = wr_ok && (cfg_wr.sel == CMT_SEL_MB_GMASK);
  wire wr_q_g = wr_ok && (cfg_wr.sel == CMT_SEL_Q_GMASK);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mb_gmask_ff <= MASK_RST;
      q_gmask_ff <= MASK_RST;
    end else begin
      if (wr_mb_g)
        mb_gmask_ff <= cfg_wr.data;
      if (wr_q_g)
        q_gmask_ff <= cfg_wr.data;
    end
  end

  // per-buffer individual masks and buffer identifiers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MB; gi++) begin : g_mb
      wire wr_m = wr_ok && wr_addr(cfg_wr, CMT_SEL_IND_MASK, IDX_W'(gi));
      wire wr_i = wr_ok && wr_addr(cfg_wr, CMT_SEL_MB_ID, IDX_W'(gi));
      // buffers taken by the queue do no buffer matching
      wire q_owned = cfg_ff.rxq_en && (gi < NUM_FLT);
      wire [ID_W-1:0] mb_mask;
      wire mb_hit;

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ind_mask_ff[gi] <= MASK_RST;
          mb_id_ff[gi] <= ID_RST;
        end else begin
          if (wr_m)
            ind_mask_ff[gi] <= cfg_wr.data;
          if (wr_i)
            mb_id_ff[gi] <= cfg_wr.data;
        end
      end

      // individual mask i on buffer i, else the global one
      assign mb_mask = cfg_ff.irmq_en ? ind_mask_ff[gi]
                                      : mb_gmask_ff;

      cmt_id_match u_mb_match (
        .en(running && rx.valid && !q_owned),
        .id(rx.id),
        .ref_id(mb_id_ff[gi]),
        .mask(mb_mask),
        .hit(mb_hit)
      );

      always_ff @(posedge clk) begin
        if (!rst_n)
          mb_hit_ff[gi] <= 1'b0;
        else
          mb_hit_ff[gi] <= mb_hit;
      end
    end
  endgenerate

  // queue filter table and its mask selection
  genvar gk;
  generate
    for (gk = 0; gk < NUM_FLT; gk++) begin : g_flt
      wire wr_f = wr_ok &&
                  wr_addr(cfg_wr, CMT_SEL_FLT_ID, IDX_W'(gk));
      wire [ID_W-1:0] flt_mask;
      wire flt_hit;

      always_ff @(posedge clk) begin
        if (!rst_n)
          flt_id_ff[gk] <= ID_RST;
        else if (wr_f)
          flt_id_ff[gk] <= cfg_wr.data;
      end

      if (gk < QMASK_LIMIT && gk < NUM_MB) begin : g_ind
        // buffer mask of the same index masks this filter
        assign flt_mask = cfg_ff.irmq_en ? ind_mask_ff[gk]
                                         : q_gmask_ff;
      end else begin : g_glb
        // high-indexed masks never reach the queue
        assign flt_mask = q_gmask_ff;
      end

      cmt_id_match u_flt_match (
        .en(running && rx.valid && cfg_ff.rxq_en),
        .id(rx.id),
        .ref_id(flt_id_ff[gk]),
        .mask(flt_mask),
        .hit(flt_hit)
      );

      always_ff @(posedge clk) begin
        if (!rst_n)
          flt_hit_ff[gk] <= 1'b0;
        else
          flt_hit_ff[gk] <= flt_hit;
      end
    end
  endgenerate

  // answer one cycle after the identifier
  always_ff @(posedge clk) begin
    if (!rst_n)
      hit_valid_ff <= 1'b0;
    else
      hit_valid_ff <= running && rx.valid;
  end

  // both nominal views and the data phase view
  wire [TQ_W-1:0] ctl_tq;
  wire [TQ_W-1:0] ctl_sp;
  wire ctl_ok;
  wire [TQ_W-1:0] ext_tq;
  wire [TQ_W-1:0] ext_sp;
  wire ext_ok;
  wire [TQ_W-1:0] dph_tq;
  wire [TQ_W-1:0] dph_sp;
  wire dph_ok;

  cmt_bit_time #(
    .PROP_W(CTL_PROP_W),
    .PS_W(CTL_PS_W),
    .MAX_TQ(CTL_MAX_TQ)
  ) u_ctl_time (
    .tseg(nom_ff.tseg),
    .tq(ctl_tq),
    .sp(ctl_sp),
    .ok(ctl_ok)
  );

  cmt_bit_time #(
    .PROP_W(EXT_PROP_W),
    .PS_W(EXT_PS_W),
    .MAX_TQ(EXT_MAX_TQ)
  ) u_ext_time (
    .tseg(nom_ff.tseg),
    .tq(ext_tq),
    .sp(ext_sp),
    .ok(ext_ok)
  );

  cmt_bit_time #(
    .PROP_W(DAT_PROP_W),
    .PS_W(DAT_PS_W),
    .MAX_TQ(DAT_MAX_TQ)
  ) u_dat_time (
    .tseg(dat_ff.tseg),
    .tq(dph_tq),
    .sp(dph_sp),
    .ok(dph_ok)
  );

  wire [TQ_W-1:0] nom_tq = nom_ff.ext_view ? ext_tq : ctl_tq;
  wire [TQ_W-1:0] nom_sp = nom_ff.ext_view ? ext_sp : ctl_sp;
  wire nom_ok = nom_ff.ext_view ? ext_ok : ctl_ok;

  // data phase timing only in use with FD enabled
  // data_phase is taken live, it is not latched
  wire use_dat = cfg_ff.fd_en && data_phase;
  wire [TQ_W-1:0] act_tq = use_dat ? dph_tq : nom_tq;
  wire [TQ_W-1:0] act_sp = use_dat ? dph_sp : nom_sp;
  wire [PDIV_W-1:0] act_pdiv = use_dat ? dat_ff.presdiv : nom_ff.presdiv;
  wire act_ok = use_dat ? dph_ok : nom_ok;

  // data quanta read as zero while FD is off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nom_tq_ff <= '0;
      dat_tq_ff <= '0;
      nom_ok_ff <= 1'b0;
      dat_ok_ff <= 1'b0;
    end else begin
      nom_tq_ff <= nom_tq;
      dat_tq_ff <= cfg_ff.fd_en ? dph_tq : '0;
      nom_ok_ff <= nom_ok;
      dat_ok_ff <= cfg_ff.fd_en && dph_ok;
    end
  end

  // quantum prescaler and position within the bit
  wire tq_end = (pdiv_cnt_ff == act_pdiv);
  // greater-or-equal wraps a bit cut short by a view switch
  wire bit_end = (tq_cnt_ff >= act_tq - 8'h01);
  wire timing_on = running && act_ok;

  // counters held at zero while halted or out of range
  always_ff @(posedge clk) begin
    if (!rst_n || !timing_on) begin
      pdiv_cnt_ff <= '0;
      tq_cnt_ff <= '0;
    end else if (tq_end) begin
      pdiv_cnt_ff <= '0;
      tq_cnt_ff <= bit_end ? '0 : tq_cnt_ff + 8'h01;
    end else begin
      pdiv_cnt_ff <= pdiv_cnt_ff + PDIV_W'(1);
    end
  end

  // sample point ends quantum sp, counted from one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tq_tick_ff <= 1'b0;
      bit_start_ff <= 1'b0;
      sample_pt_ff <= 1'b0;
    end else begin
      tq_tick_ff <= timing_on && tq_end;
      bit_start_ff <= timing_on && tq_end && bit_end;
      sample_pt_ff <= timing_on && tq_end &&
                      (tq_cnt_ff == act_sp - 8'h01);
    end
  end

endmodule // cmt_core

//--- cmt_pkg.sv
// constants, types and shared functions for the mask and bit timing block
// assumes a single 40 MHz clock domain and a synchronous active-low reset
package cmt_pkg;

  localparam int ID_W = 32;
  localparam int TQ_W = 8;
  localparam int IDX_W = 8;
  localparam int PDIV_W = 10;
  localparam logic [TQ_W-1:0] MIN_TQ = 8'h08;
  localparam logic [TQ_W-1:0] CTL_MAX_TQ = 8'h19;
  localparam logic [TQ_W-1:0] EXT_MAX_TQ = 8'h81;
  localparam logic [TQ_W-1:0] DAT_MAX_TQ = 8'h31;
  localparam int QMASK_LIMIT = 32;
  // field widths of each timing view
  localparam int CTL_PROP_W = 3;
  localparam int CTL_PS_W = 3;
  localparam int EXT_PROP_W = 6;
  localparam int EXT_PS_W = 5;
  localparam int DAT_PROP_W = 5;
  localparam int DAT_PS_W = 3;
  localparam logic [ID_W-1:0] MASK_RST = 32'hFFFFFFFF;
  localparam logic [ID_W-1:0] ID_RST = 32'h00000000;

  typedef enum logic [2:0] {
    CMT_SEL_IND_MASK,
    CMT_SEL_MB_ID,
    CMT_SEL_FLT_ID,
    CMT_SEL_MB_GMASK,
    CMT_SEL_Q_GMASK
  } cmt_sel_t;

  typedef struct packed {
    logic wr;
    cmt_sel_t sel;
    logic [IDX_W-1:0] idx;
    logic [ID_W-1:0] data;
  } cmt_wr_t;

  typedef struct packed {
    logic irmq_en;
    logic rxq_en;
    logic fd_en;
  } cmt_cfg_t;

  typedef struct packed {
    logic [5:0] prop;
    logic [4:0] ps1;
    logic [4:0] ps2;
  } cmt_tseg_t;

  typedef struct packed {
    logic ext_view;
    logic [PDIV_W-1:0] presdiv;
    cmt_tseg_t tseg;
  } cmt_nom_t;

  typedef struct packed {
    logic [PDIV_W-1:0] presdiv;
    cmt_tseg_t tseg;
  } cmt_dat_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
  } cmt_rx_t;

  // set mask bit demands equality, clear bit ignores it
  function automatic logic cmt_match(input logic [ID_W-1:0] id,
                                     input logic [ID_W-1:0] ref_id,
                                     input logic [ID_W-1:0] mask);
    cmt_match = ((id ^ ref_id) & mask) == '0;
  endfunction

endpackage

//--- cmt_bit_time.sv
// quanta count and sample point of one timing view
// assumes segment fields hold value minus one, as loaded into hardware
`timescale 1ns/1ps
module cmt_bit_time #(
  parameter int PROP_W = 3,
  parameter int PS_W = 3,
  parameter logic [cmt_pkg::TQ_W-1:0] MAX_TQ = 8'h19
) (
  input cmt_pkg::cmt_tseg_t tseg,
  output logic [cmt_pkg::TQ_W-1:0] tq,
  output logic [cmt_pkg::TQ_W-1:0] sp,
  output logic ok
);
  import cmt_pkg::*;

  wire [TQ_W-1:0] prop_q = TQ_W'(tseg.prop[PROP_W-1:0]) + 8'h01;
  wire [TQ_W-1:0] ps1_q = TQ_W'(tseg.ps1[PS_W-1:0]) + 8'h01;
  wire [TQ_W-1:0] ps2_q = TQ_W'(tseg.ps2[PS_W-1:0]) + 8'h01;

  // sync quantum plus segments up to the sample point
  assign sp = 8'h01 + prop_q + ps1_q;
  assign tq = sp + ps2_q;
  assign ok = (tq >= MIN_TQ) && (tq <= MAX_TQ);

endmodule // cmt_bit_time

//--- cmt_id_match.sv
// one masked identifier comparison
// assumes mask and reference are already selected by the caller
`timescale 1ns/1ps
module cmt_id_match (
  input wire logic en,
  input wire logic [cmt_pkg::ID_W-1:0] id,
  input wire logic [cmt_pkg::ID_W-1:0] ref_id,
  input wire logic [cmt_pkg::ID_W-1:0] mask,
  output logic hit
);
  import cmt_pkg::*;

  assign hit = en && cmt_match(id, ref_id, mask);

endmodule // cmt_id_match

//--- cmt_core_asserts.sv
// assertions on the mask and bit timing core ports
// assumes one clock domain, bound into every cmt_core
`timescale 1ns/1ps
module cmt_core_asserts #(
  parameter int NUM_MB = 16,
  parameter int NUM_FLT = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic halt_req,
  input cmt_pkg::cmt_cfg_t cfg,
  input cmt_pkg::cmt_nom_t nom_cfg,
  input cmt_pkg::cmt_dat_t dat_cfg,
  input cmt_pkg::cmt_rx_t rx,
  input wire logic frozen_ff,
  input wire logic hit_valid_ff,
  input wire logic [NUM_MB-1:0] mb_hit_ff,
  input wire logic [NUM_FLT-1:0] flt_hit_ff,
  input wire logic [7:0] nom_tq_ff,
  input wire logic [7:0] dat_tq_ff,
  input wire logic nom_ok_ff,
  input wire logic tq_tick_ff
);
  import cmt_pkg::*;
  cmt_cfg_t c_ff;
  cmt_nom_t n_ff;
  cmt_dat_t d_ff;
  cmt_tseg_t nt;
  cmt_tseg_t dt;
  logic [7:0] ntq;
  logic [7:0] dtq;
  logic nok;
  // shadow of settings latched while halted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c_ff <= '0;
      n_ff <= '0;
      d_ff <= '0;
    end else if (frozen_ff) begin
      c_ff <= cfg;
      n_ff <= nom_cfg;
      d_ff <= dat_cfg;
    end
  end
  assign nt = n_ff.tseg;
  assign dt = d_ff.tseg;
  assign ntq = n_ff.ext_view ? 8'(nt.prop) + 8'(nt.ps1) + 8'(nt.ps2) + 8'h04
    : 8'(nt.prop[2:0]) + 8'(nt.ps1[2:0]) + 8'(nt.ps2[2:0]) + 8'h04;
  assign dtq = 8'(dt.prop[4:0]) + 8'(dt.ps1[2:0]) + 8'(dt.ps2[2:0]) + 8'h04;
  assign nok = ntq >= MIN_TQ
    && ntq <= (n_ff.ext_view ? EXT_MAX_TQ : CTL_MAX_TQ);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  halt_follow_a: assert property (
    $past(rst_n) |-> frozen_ff == $past(halt_req))
    else $error("halt state lags request");
  hit_time_a: assert property (
    $past(rst_n) |-> hit_valid_ff == $past(rx.valid && !frozen_ff))
    else $error("match answer timing wrong");
  q_owns_mb_a: assert property (
    c_ff.rxq_en |-> mb_hit_ff[NUM_FLT-1:0] == '0)
    else $error("queue buffer hit");
  flt_off_a: assert property (
    !c_ff.rxq_en |-> flt_hit_ff == '0)
    else $error("filter hit with queue off");
  nom_tq_a: assert property (
    $past(rst_n) && $past(rst_n, 2) |-> nom_tq_ff == $past(ntq))
    else $error("nominal quanta wrong");
  nom_ok_a: assert property (
    $past(rst_n) && $past(rst_n, 2) |-> nom_ok_ff == $past(nok))
    else $error("nominal range flag wrong");
  dat_tq_a: assert property (
    $past(rst_n) && $past(rst_n, 2)
    |-> dat_tq_ff == $past(c_ff.fd_en ? dtq : 8'h00))
    else $error("data quanta wrong");
  idle_tick_a: assert property (
    frozen_ff [*3] |-> !tq_tick_ff)
    else $error("tick while halted");
endmodule // cmt_core_asserts

bind cmt_core cmt_core_asserts #(.NUM_MB(NUM_MB), .NUM_FLT(NUM_FLT))
  u_cmt_core_asserts (
  .clk(clk), .rst_n(rst_n), .halt_req(halt_req), .cfg(cfg),
  .nom_cfg(nom_cfg), .dat_cfg(dat_cfg), .rx(rx), .frozen_ff(frozen_ff),
  .hit_valid_ff(hit_valid_ff), .mb_hit_ff(mb_hit_ff),
  .flt_hit_ff(flt_hit_ff), .nom_tq_ff(nom_tq_ff), .dat_tq_ff(dat_tq_ff),
  .nom_ok_ff(nom_ok_ff), .tq_tick_ff(tq_tick_ff));

//--- cmt_node_model.sv
// far bus node handing received identifiers to the core
// assumes send is entered just after a rising clock edge
`timescale 1ns/1ps
module cmt_node_model (
  input wire logic clk,
  output cmt_pkg::cmt_rx_t rx
);
  import cmt_pkg::*;
  initial rx = '{valid: 1'b0, id: 32'h0};
  // idle id line shows inverse, never the stale value
  task automatic send(input logic [ID_W-1:0] id);
    rx = '{valid: 1'b1, id: id};
    @(posedge clk);
    #2;
    rx = '{valid: 1'b0, id: ~id};
  endtask
endmodule // cmt_node_model

//--- can_rx_mask_bit_timing_tb.sv
// bench for the mask and bit timing core
// assumes the node model feeds identifiers
`timescale 1ns/1ps
module can_rx_mask_bit_timing_tb;
  import cmt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic halt_req = 1'b1;
  logic data_phase = 1'b0;
  cmt_cfg_t cfg = '0;
  cmt_wr_t cfg_wr = '0;
  cmt_nom_t nom_cfg = '0;
  cmt_dat_t dat_cfg = '0;
  cmt_rx_t rx;
  logic fz, hv, nok, dok, tick, bs, sp;
  logic [35:0] mb;
  logic [33:0] flt;
  logic [7:0] ntq, dtq;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  cmt_core #(.NUM_MB(36), .NUM_FLT(34)) u_cmt_core (
    .clk(clk), .rst_n(rst_n), .halt_req(halt_req), .cfg(cfg),
    .cfg_wr(cfg_wr), .nom_cfg(nom_cfg), .dat_cfg(dat_cfg),
    .data_phase(data_phase), .rx(rx), .frozen_ff(fz), .hit_valid_ff(hv),
    .mb_hit_ff(mb), .flt_hit_ff(flt), .nom_tq_ff(ntq), .dat_tq_ff(dtq),
    .nom_ok_ff(nok), .dat_ok_ff(dok), .tq_tick_ff(tick),
    .bit_start_ff(bs), .sample_pt_ff(sp));
  cmt_node_model u_cmt_node_model (.clk(clk), .rx(rx));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input cmt_sel_t s, input logic [7:0] i,
                    input logic [31:0] d);
    cfg_wr = '{wr: 1'b1, sel: s, idx: i, data: d};
    step(1);
    cfg_wr.wr = 1'b0;
    step(1);
  endtask
  task automatic run(input logic h);
    halt_req = h;
    step(2);
  endtask
  task automatic hit(input logic [31:0] id, input logic [63:0] m,
                     input logic [63:0] f);
    u_cmt_node_model.send(id);
    chk(64'(hv), 64'h1);
    chk(64'(mb), m);
    chk(64'(flt), f);
  endtask
  task automatic tm(input cmt_nom_t n, input logic [8:0] e);
    nom_cfg = n;
    step(2);
    chk(64'({ntq, nok}), 64'(e));
  endtask
  // counts pulses over n cycles; window is a whole number of bits
  task automatic pulses(input int n, input logic [63:0] et,
                        input logic [63:0] eb);
    int t;
    int b;
    int s;
    t = 0;
    b = 0;
    s = 0;
    repeat (n) begin
      step(1);
      t += tick;
      b += bs;
      s += sp;
    end
    chk(64'(t), et);
    chk(64'(b), eb);
    chk(64'(s), eb);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    step(2);
    rst_n = 1'b1;
    chk(64'({fz, hv, nok}), 64'h4);
    u_cmt_node_model.send(32'h0);
    chk(64'(hv), 64'h0);
    $display("test reset done");
    tm('{1'b0, 10'h0, '{6'h07, 5'h07, 5'h07}}, {8'h19, 1'b1});
    tm('{1'b0, 10'h0, '{6'h08, 5'h01, 5'h03}}, {8'h08, 1'b1});
    tm('{1'b0, 10'h0, '{6'h00, 5'h01, 5'h02}}, {8'h07, 1'b0});
    tm('{1'b1, 10'h0, '{6'h3F, 5'h1F, 5'h1F}}, {8'h81, 1'b1});
    tm('{1'b1, 10'h0, '{6'h08, 5'h08, 5'h08}}, {8'h1C, 1'b1});
    cfg.fd_en = 1'b1;
    dat_cfg = '{10'h0, '{6'h1F, 5'h07, 5'h07}};
    step(2);
    chk(64'({dtq, dok, ntq}), 64'({8'h31, 1'b1, 8'h1C}));
    $display("test timing done");
    wr(CMT_SEL_MB_ID, 8'h03, 32'h123);
    wr(CMT_SEL_MB_GMASK, 8'h00, 32'hFFFFFF00);
    run(1'b0);
    step(1);
    chk(64'(tick), 64'h1);
    hit(32'h1AB, 64'h8, 64'h0);
    wr(CMT_SEL_MB_GMASK, 8'h00, 32'h0);
    hit(32'h1AB, 64'h8, 64'h0);
    run(1'b1);
    cfg.irmq_en = 1'b1;
    wr(CMT_SEL_IND_MASK, 8'h03, 32'hFFFFFF00);
    wr(CMT_SEL_IND_MASK, 8'h05, 32'h0);
    run(1'b0);
    hit(32'h1AB, 64'h28, 64'h0);
    $display("test mask done");
    run(1'b1);
    cfg.rxq_en = 1'b1;
    wr(CMT_SEL_FLT_ID, 8'h02, 32'h55);
    wr(CMT_SEL_IND_MASK, 8'h02, 32'hFFFFFFF0);
    wr(CMT_SEL_IND_MASK, 8'h21, 32'h0);
    wr(CMT_SEL_IND_MASK, 8'h23, 32'h0);
    run(1'b0);
    hit(32'h5A, 64'h800000000, 64'h2C);
    run(1'b1);
    cfg.irmq_en = 1'b0;
    wr(CMT_SEL_Q_GMASK, 8'h00, 32'hFFFFFFF0);
    run(1'b0);
    hit(32'h5A, 64'hC00000000, 64'h4);
    $display("test queue done");
    run(1'b1);
    // 8 quanta of 2 clocks: 16 clocks a bit
    nom_cfg = '{1'b0, 10'h1, '{6'h08, 5'h01, 5'h03}};
    run(1'b0);
    pulses(32, 64'h10, 64'h2);
    run(1'b1);
    // data view of 49 quanta, 1 clock each
    data_phase = 1'b1;
    run(1'b0);
    pulses(98, 64'h62, 64'h2);
    $display("test pulses done");
    wrap_up();
  end
endmodule // can_rx_mask_bit_timing_tb
